//--- ifr_evt_irq.sv
// Sticky event status with enable mask, write-one-to-clear and one level interrupt.
// Assumes event pulses and strobes are on the same clock.
`timescale 1ns/1ps
module ifr_evt_irq
	import ifr_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	input  wire logic [EVT_NUM-1:0]  evt_i,
	input  wire logic                en_wr_i,
	input  wire logic                clr_wr_i,
	input  wire logic [7:0]          wdata_i,
	output logic      [EVT_NUM-1:0]  status_o,
	output logic      [EVT_NUM-1:0]  enable_o,
	output logic                     irq_o
);
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			enable_o <= EVT_RST[EVT_NUM-1:0];
		end else if (en_wr_i) begin
			enable_o <= wdata_i[EVT_NUM-1:0];
		end
	end

	// A new event in the clearing cycle keeps its status bit.
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			status_o <= EVT_RST[EVT_NUM-1:0];
		end else begin
			status_o <= evt_i | (status_o & ~(clr_wr_i ? wdata_i[EVT_NUM-1:0] : '0));
		end
	end

	assign irq_o = |(status_o & enable_o);
endmodule

//--- ifr_flag_reg.sv
// Byte-wide register of sticky flags with software write and hardware set and clear.
// Assumes set and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
module ifr_flag_reg
	import ifr_pkg::*;
#(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK    = 8'hFF
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] set_i,
	input  wire logic [7:0] hw_clr_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] q_o
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			if (MASK[i]) begin : g_impl
				// A hardware set beats both a write of zero and a vectoring clear.
				always_ff @(posedge clk_sys_i) begin
					if (!rstn_i) begin
						q_o[i] <= RST_VAL[i];
					end else if (set_i[i]) begin
						q_o[i] <= 1'b1;
					end else if (wr_i) begin
						q_o[i] <= wdata_i[i];
					end else if (hw_clr_i[i]) begin
						q_o[i] <= 1'b0;
					end
				end
			end else begin : g_none
				assign q_o[i] = 1'b0;
			end
		end
	endgenerate
endmodule

//--- ifr_flags.sv
// Top of the interrupt flag register part: main and cipher flag registers, event status.
// Assumes peripherals and the CPU core run on clk_sys_i and give one-cycle strobes.
`timescale 1ns/1ps
module ifr_flags
	import ifr_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       serial1_rx_evt_i,
	input  wire logic       audio_rx_evt_i,
	input  wire logic       converter_evt_i,
	input  wire logic       serial0_rx_evt_i,
	input  wire logic       radio_txrx_evt_i,
	input  wire logic       cipher_evt_i,
	input  wire logic       cipher_mod_clr_i,
	input  wire logic       cipher_mod_left_i,
	input  wire logic       vec_serial1_i,
	input  wire logic       vec_converter_i,
	input  wire logic       vec_serial0_i,
	input  wire logic       vec_radio_i,
	output logic            serial1_rx_pending_o,
	output logic            converter_done_pending_o,
	output logic            serial0_rx_pending_o,
	output logic            radio_txrx_done_pending_o,
	output logic            cipher_pending_o,
	output logic            irq_o
);
	logic [7:0]         interrupt_flag_main;
	logic [7:0]         interrupt_flag_cipher;
	logic [7:0]         main_set;
	logic [7:0]         main_clr;
	logic [7:0]         ciph_set;
	logic               cipher_reset_req;
	logic [EVT_NUM-1:0] evt;
	logic [EVT_NUM-1:0] evt_status;
	logic [EVT_NUM-1:0] evt_enable;
	logic [7:0]         next_rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Remaining enabled module flags raise the cipher request again after a clear.
	assign cipher_reset_req = cipher_mod_clr_i & cipher_mod_left_i;

	// Flags are set on the event itself; enabling happens outside this part.
	always_comb begin
		main_set = 8'h00;
		main_set[BIT_SERIAL1] = serial1_rx_evt_i | audio_rx_evt_i;
		main_set[BIT_CONV]    = converter_evt_i;
		main_set[BIT_SERIAL0] = serial0_rx_evt_i;
		main_set[BIT_RADIO]   = radio_txrx_evt_i;
		main_clr = 8'h00;
		main_clr[BIT_SERIAL1] = vec_serial1_i;
		main_clr[BIT_CONV]    = vec_converter_i;
		main_clr[BIT_SERIAL0] = vec_serial0_i;
		main_clr[BIT_RADIO]   = vec_radio_i;
		ciph_set = 8'h00;
		ciph_set[BIT_CIPH_HI] = cipher_evt_i | cipher_reset_req;
		ciph_set[BIT_CIPH_LO] = cipher_evt_i | cipher_reset_req;
	end

	// Reserved bits come out of reset at one and hold what software writes.
	ifr_flag_reg #(
		.RST_VAL(MAIN_RST),
		.MASK   (MAIN_MASK)
	) u_main (
		.clk_sys_i(clk_sys_i),
		.rstn_i   (rstn_i),
		.set_i    (main_set),
		.hw_clr_i (main_clr),
		.wr_i     (wr_i & hit(addr_i, ADDR_MAIN)),
		.wdata_i  (wdata_i),
		.q_o      (interrupt_flag_main)
	);

	ifr_flag_reg #(
		.RST_VAL(CIPH_RST),
		.MASK   (CIPH_MASK)
	) u_cipher (
		.clk_sys_i(clk_sys_i),
		.rstn_i   (rstn_i),
		.set_i    (ciph_set),
		.hw_clr_i (8'h00),
		.wr_i     (wr_i & hit(addr_i, ADDR_CIPHER)),
		.wdata_i  (wdata_i),
		.q_o      (interrupt_flag_cipher)
	);

	always_comb begin
		evt = '0;
		evt[EVT_SERIAL1] = serial1_rx_evt_i;
		evt[EVT_AUDIO]   = audio_rx_evt_i;
		evt[EVT_CONV]    = converter_evt_i;
		evt[EVT_SERIAL0] = serial0_rx_evt_i;
		evt[EVT_RADIO]   = radio_txrx_evt_i;
		evt[EVT_CIPHER]  = cipher_evt_i;
	end

	ifr_evt_irq u_irq (
		.clk_sys_i(clk_sys_i),
		.rstn_i   (rstn_i),
		.evt_i    (evt),
		.en_wr_i  (wr_i & hit(addr_i, ADDR_EVT_ENABLE)),
		.clr_wr_i (wr_i & hit(addr_i, ADDR_EVT_CLEAR)),
		.wdata_i  (wdata_i),
		.status_o (evt_status),
		.enable_o (evt_enable),
		.irq_o    (irq_o)
	);

	// Pending outputs mirror the flag bits for the vector arbitration outside.
	assign serial1_rx_pending_o      = interrupt_flag_main[BIT_SERIAL1];
	assign converter_done_pending_o  = interrupt_flag_main[BIT_CONV];
	assign serial0_rx_pending_o      = interrupt_flag_main[BIT_SERIAL0];
	assign radio_txrx_done_pending_o = interrupt_flag_main[BIT_RADIO];
	assign cipher_pending_o          = interrupt_flag_cipher[BIT_CIPH_HI]
	                                 | interrupt_flag_cipher[BIT_CIPH_LO];

	always_comb begin
		next_rdata = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, ADDR_MAIN)) begin
				next_rdata = interrupt_flag_main;
			end else if (hit(addr_i, ADDR_CIPHER)) begin
				next_rdata = interrupt_flag_cipher;
			end else if (hit(addr_i, ADDR_EVT_STATUS)) begin
				next_rdata = {{(8-EVT_NUM){1'b0}}, evt_status};
			end else if (hit(addr_i, ADDR_EVT_ENABLE)) begin
				next_rdata = {{(8-EVT_NUM){1'b0}}, evt_enable};
			end
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= next_rdata;
		end
	end
endmodule

//--- ifr_monitor.sv
// Assertions on the ports of ifr_flags.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ifr_monitor
	import ifr_pkg::*;
(
	input wire logic       clk_sys_i,
	input wire logic       rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       serial1_rx_evt_i,
	input wire logic       audio_rx_evt_i,
	input wire logic       converter_evt_i,
	input wire logic       serial0_rx_evt_i,
	input wire logic       radio_txrx_evt_i,
	input wire logic       cipher_evt_i,
	input wire logic       cipher_mod_clr_i,
	input wire logic       cipher_mod_left_i,
	input wire logic       vec_converter_i,
	input wire logic       serial1_rx_pending_o,
	input wire logic       converter_done_pending_o,
	input wire logic       serial0_rx_pending_o,
	input wire logic       radio_txrx_done_pending_o,
	input wire logic       cipher_pending_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	wire main_wr = wr_i && addr_i == ADDR_MAIN;
	rx1_set_a: assert property ((serial1_rx_evt_i || audio_rx_evt_i) |=> serial1_rx_pending_o)
		else $error("serial1 flag not set");
	conv_set_a: assert property (converter_evt_i |=> converter_done_pending_o)
		else $error("converter flag not set");
	conv_clr_a: assert property (vec_converter_i && !converter_evt_i && !main_wr
		|=> !converter_done_pending_o) else $error("converter flag kept");
	rx0_set_a: assert property (serial0_rx_evt_i |=> serial0_rx_pending_o)
		else $error("serial0 flag not set");
	radio_set_a: assert property (radio_txrx_evt_i |=> radio_txrx_done_pending_o)
		else $error("radio flag not set");
	cipher_set_a: assert property (cipher_evt_i |=> cipher_pending_o)
		else $error("cipher flag not set");
	wr_clear_a: assert property (main_wr && !wdata_i[3] && !serial0_rx_evt_i
		|=> !serial0_rx_pending_o) else $error("serial0 flag kept");
	cipher_reset_a: assert property (cipher_mod_clr_i && cipher_mod_left_i |=> cipher_pending_o)
		else $error("cipher flag not renewed");
	cover property (vec_converter_i && converter_done_pending_o);
	cover property (main_wr && converter_evt_i);
	cover property (cipher_mod_clr_i && cipher_mod_left_i);
endmodule

//--- ifr_pkg.sv
// Constants for the interrupt flag register part: offsets, bit positions and reset values.
// Assumes an 8-bit register port in the CPU clock domain with a synchronous active-low reset.
// Operation
// - Second serial or audio receive sets main bit 7; vectoring clears it.
// - Converter done sets main bit 5; vectoring clears it.
// - First serial receive sets main bit 3; vectoring clears it.
// - Radio transmit/receive done sets main bit 1; vectoring clears it.
// - Main bits 2 and 0 reset to one; software always writes ones there.
// - Flags read one while pending, zero otherwise; reset to zero except reserved.
// - Either cipher flag, bit 1 or 0, set by anyone requests cipher service.
// - A cipher coprocessor request sets both cipher flags in one cycle.
// - Flags set regardless of enable; enabled set flags get vectored next cycle.
// - On any module flag clear, remaining enabled set flags re-set the CPU flag.
package ifr_pkg;
	localparam logic [7:0] ADDR_MAIN       = 8'h88;
	localparam logic [7:0] ADDR_CIPHER     = 8'h98;
	localparam logic [7:0] ADDR_EVT_STATUS = 8'hA0;
	localparam logic [7:0] ADDR_EVT_ENABLE = 8'hA1;
	localparam logic [7:0] ADDR_EVT_CLEAR  = 8'hA2;

	localparam int BIT_SERIAL1 = 7;
	localparam int BIT_CONV    = 5;
	localparam int BIT_SERIAL0 = 3;
	localparam int BIT_RSV_HI  = 2;
	localparam int BIT_RADIO   = 1;
	localparam int BIT_RSV_LO  = 0;
	localparam int BIT_CIPH_HI = 1;
	localparam int BIT_CIPH_LO = 0;

	localparam logic [7:0] MAIN_RST   = 8'h05;
	localparam logic [7:0] MAIN_MASK  = 8'hFF;
	localparam logic [7:0] CIPH_RST   = 8'h00;
	localparam logic [7:0] CIPH_MASK  = 8'hC3;
	localparam logic [7:0] EVT_RST    = 8'h00;

	localparam int EVT_SERIAL1 = 0;
	localparam int EVT_AUDIO   = 1;
	localparam int EVT_CONV    = 2;
	localparam int EVT_SERIAL0 = 3;
	localparam int EVT_RADIO   = 4;
	localparam int EVT_CIPHER  = 5;
	localparam int EVT_NUM     = 6;
endpackage

//--- ifr_src_model.sv
// Model of the CPU core and the peripheral event sources.
// Assumes bits 5:0 are events, 9:6 vector takes, 10 module clear, 11 flag left.
`timescale 1ns/1ps
module ifr_src_model (
	input  wire logic        clk_sys_i,
	output logic      [11:0] strb_o
);
	initial strb_o = '0;
	// Vectoring never comes with a software clear of the flag.
	task automatic fire(input logic [11:0] m);
		@(posedge clk_sys_i) strb_o <= m;
		@(posedge clk_sys_i) strb_o <= '0;
	endtask
endmodule

//--- tb_top.sv
// Self-checking bench of ifr_flags with its source model.
// Assumes the checker and the model are compiled first.
`timescale 1ns/1ps
module tb_top
	import ifr_pkg::*;
;
	logic        clk_sys_i = 0;
	logic        rstn_i = 0;
	logic  [7:0] addr_i = '0;
	logic  [7:0] wdata_i = '0;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic  [7:0] rdata_o;
	logic [11:0] s;
	logic  [4:0] po;
	logic        irq;
	int          fail_count = 0;
	int          total_checks = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	ifr_src_model u_ifr_src_model (.clk_sys_i(clk_sys_i), .strb_o(s));
	ifr_flags u_ifr_flags (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.serial1_rx_evt_i(s[0]), .audio_rx_evt_i(s[1]), .converter_evt_i(s[2]),
		.serial0_rx_evt_i(s[3]), .radio_txrx_evt_i(s[4]), .cipher_evt_i(s[5]),
		.vec_serial1_i(s[6]), .vec_converter_i(s[7]), .vec_serial0_i(s[8]),
		.vec_radio_i(s[9]), .cipher_mod_clr_i(s[10]), .cipher_mod_left_i(s[11]),
		.serial1_rx_pending_o(po[4]), .converter_done_pending_o(po[3]),
		.serial0_rx_pending_o(po[2]), .radio_txrx_done_pending_o(po[1]),
		.cipher_pending_o(po[0]), .irq_o(irq));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge clk_sys_i) wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i) {addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_sys_i) rd_i <= 0;
		#1 chk("rdata", e, rdata_o);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_events();
		rd(ADDR_MAIN, 8'h05);
		rd(ADDR_CIPHER, 8'h00);
		u_ifr_src_model.fire(12'h01D);
		rd(ADDR_MAIN, 8'hAF);
		chk("pending", 8'h1E, {3'b0, po});
		u_ifr_src_model.fire(12'h3C0);
		rd(ADDR_MAIN, 8'h05);
		u_ifr_src_model.fire(12'h002);
		rd(ADDR_MAIN, 8'h85);
		wr(ADDR_MAIN, 8'h05);
		rd(ADDR_MAIN, 8'h05);
	endtask
	task automatic t_race();
		fork
			u_ifr_src_model.fire(12'h004);
			wr(ADDR_MAIN, 8'h05);
		join
		rd(ADDR_MAIN, 8'h25);
		#1 chk("irq", 8'h00, {7'b0, irq});
		wr(ADDR_EVT_ENABLE, 8'h04);
		#1 chk("irq", 8'h01, {7'b0, irq});
		rd(ADDR_EVT_STATUS, 8'h1F);
		wr(ADDR_EVT_CLEAR, 8'h04);
		#1 chk("irq", 8'h00, {7'b0, irq});
		rd(8'hA5, 8'h00);
		u_ifr_src_model.fire(12'h080);
		rd(ADDR_MAIN, 8'h05);
	endtask
	task automatic t_cipher();
		u_ifr_src_model.fire(12'h020);
		rd(ADDR_CIPHER, 8'h03);
		wr(ADDR_CIPHER, 8'h01);
		#1 chk("cipher", 8'h01, {7'b0, po[0]});
		wr(ADDR_CIPHER, 8'hFF);
		rd(ADDR_CIPHER, 8'hC3);
		wr(ADDR_CIPHER, 8'h00);
		u_ifr_src_model.fire(12'hC00);
		rd(ADDR_CIPHER, 8'h03);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rstn_i <= 1;
		t_events();
		t_race();
		t_cipher();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fail_count++;
		conclude();
	end
endmodule
bind ifr_flags ifr_monitor u_ifr_monitor (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
	.serial1_rx_evt_i, .audio_rx_evt_i, .converter_evt_i, .serial0_rx_evt_i,
	.radio_txrx_evt_i, .cipher_evt_i, .cipher_mod_clr_i, .cipher_mod_left_i,
	.vec_converter_i, .serial1_rx_pending_o, .converter_done_pending_o,
	.serial0_rx_pending_o, .radio_txrx_done_pending_o, .cipher_pending_o);
